/* File: rdc_pkg.sv */
package rdc_pkg;

    // ----------------------------------------
    // Instruction field positions
    // ----------------------------------------
    localparam int REG_W = 4;
    localparam int RX_LSB = 0;
    localparam int RY_LSB = 4;
    localparam int RZ_LSB = 8;
    localparam int IMM_LSB = 4;
    localparam int IMM5_W = 5;
    localparam int IMM7_W = 7;
    localparam int DISP8_W = 8;
    localparam int DISP11_W = 11;
    localparam int UNIT_LSB = 10;

    // ----------------------------------------
    // Fixed register numbers and constants
    // ----------------------------------------
    localparam logic [3:0] QUAD_FIRST = 4'h4;
    localparam logic [3:0] QUAD_LAST = 4'h7;
    localparam logic [3:0] RANGE_LAST = 4'hF;
    localparam logic [3:0] IND_GOTO_Z = 4'h0;
    localparam logic [3:0] IND_CALL_Z = 4'hF;
    localparam logic [31:0] PC_STEP = 32'h0000_0002;
    localparam logic [31:0] MASK_ALL_IMM = 32'h0000_0020;
    localparam logic [31:0] OFFSET_ONE = 32'h0000_0001;
    localparam logic [4:0] IMM_ZERO = 5'h00;
    localparam logic [4:0] IMM_UDIV = 5'h01;
    localparam logic [4:0] IMM_SDIV = 5'h01;
    localparam logic [4:0] IMM_BGEN_LOW = 5'h07;
    localparam logic [1:0] TRAP_SEL = 2'h2;

    // ----------------------------------------
    // Memory access sizes
    // ----------------------------------------
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // ----------------------------------------
    // Decoded operations
    // ----------------------------------------
    typedef enum logic [6:0] {
        op_illegal, op_debug_halt, op_sync, op_exception_return, op_fast_irq_return, op_stop, op_wait,
        op_light_sleep, op_trap, op_mvc, op_mvcv, op_load_quad_regs, op_save_quad_regs, op_load_reg_range,
        op_save_reg_range, op_dect, op_decf, op_inct, op_incf, op_register_goto, op_register_call, op_ff1,
        op_brev, op_xtrb3, op_xtrb2, op_xtrb1, op_xtrb0, op_zextb, op_sextb, op_zexth, op_sexth, op_declt,
        op_tstnbz, op_decgt, op_decne, op_clrt, op_clrf, op_abs, op_not, op_movt, op_mult, op_loopt, op_subu,
        op_addc, op_subc, op_movf, op_lsr, op_cmphs, op_cmplt, op_tst, op_cmpne, op_control_reg_read, op_mov,
        op_bgenr, op_rsub, op_ixw, op_and, op_xor, op_control_reg_write, op_asr, op_lsl, op_addu, op_ixh,
        op_or, op_andn, op_addi, op_cmplti, op_subi, op_rsubi, op_cmpnei, op_low_ones_mask_const,
        op_unsigned_divide, op_andi, op_bclri, op_signed_divide, op_single_bit_const, op_bseti, op_btsti,
        op_extended_right_shift, op_rotate_left_const, op_asrc, op_asri, op_logical_left_shift_carry,
        op_lsli, op_logical_right_shift_carry, op_lsri, op_accel_execute, op_accel_result_fetch,
        op_accel_call, op_accel_mem_load, op_accel_mem_store, op_accel_mem_load_half,
        op_accel_mem_store_half, op_small_const_load, op_pc_relative_word_load, op_indirect_goto,
        op_indirect_call, op_load_word, op_save_word, op_load_byte, op_save_byte, op_load_half,
        op_save_half, op_goto_if_set, op_goto_if_clear, op_relative_goto, op_relative_call
    } rdc_op_t;

endpackage

/* File: rdc_pc_adder.sv */
`timescale 1ns/1ps

module rdc_pc_adder #(
    parameter bit CLEAR_LOW = 1'b0
) (
    // Operands
    input wire logic [31:0] pc_in,
    input wire logic [31:0] offset_in,
    // Result
    output logic [31:0] addr_out
);

    // ----------------------------------------
    // PC plus two plus scaled offset
    // ----------------------------------------
    logic [31:0] sum;

    always_comb begin
        sum = pc_in + rdc_pkg::PC_STEP + offset_in;
        addr_out = CLEAR_LOW ? {sum[31:2], 2'b00} : sum;
    end

endmodule

/* File: rdc_decoder.sv */
`timescale 1ns/1ps

// Contract
// [RQ1] Scaled-immediate load/store address, data register
// [RQ2] Quad transfer moves R4 to R7
// [RQ3] Range transfer list start to R15, R0
// [RQ4] PC-relative load word-aligned address
// [RQ5] Indirect goto/call same aligned address
// [RQ6] Odd fetched target raises misaligned exception
// [RQ7] Branch target PC+2 plus displacement times two
// [RQ8] Register goto/call target from register
// [RQ9] Loop target uses ones-extended displacement
// [RQ10] Special words, trap numbers, undefined word
// [RQ11] Single-register group opcode and register
// [RQ12] Two-register fields; 0x08, 0x09 undefined
// [RQ13] Control register specifier in bits 8:4
// [RQ14] Five-bit immediate and register fields
// [RQ15] Zero immediate selects carry shift forms
// [RQ16] Mask and bit spaces hold divides
// [RQ17] Prefix 0100 is accelerator operations
// [RQ18] Small constant load seven-bit immediate
// [RQ19] Prefix 0111 PC-relative load, indirect forms
// [RQ20] Top five bits select branch kinds
// [RQ21] Load/store nibble prefixes and fields
// [RQ22] Offset immediates mean encoding plus one
// [RQ23] Undefined encodings flagged as illegal
// [RQ24] Decode combinational from latched word
module rdc_decoder (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Fetch stage
    input wire logic fetch_valid_in,
    input wire logic [15:0] fetch_instr_in,
    input wire logic [31:0] fetch_pc_in,
    // Register file values
    input wire logic [31:0] rx_value_in,
    input wire logic [31:0] r0_value_in,
    // Word fetched by indirect forms
    input wire logic ind_word_valid_in,
    input wire logic [31:0] ind_word_in,
    // Decoded operation
    output logic dec_valid_out,
    output rdc_pkg::rdc_op_t dec_op_out,
    output logic illegal_out,
    output logic [3:0] rx_sel_out,
    output logic [3:0] ry_sel_out,
    output logic [3:0] rz_sel_out,
    output logic [4:0] creg_out,
    output logic [31:0] imm_out,
    output logic [1:0] trap_num_out,
    // Accelerator fields
    output logic [1:0] accel_unit_out,
    output logic [7:0] accel_exec_out,
    output logic [2:0] accel_count_out,
    output logic accel_update_out,
    // Memory port controls
    output logic mem_read_out,
    output logic mem_write_out,
    output logic [1:0] mem_size_out,
    output logic [31:0] mem_addr_out,
    output logic [3:0] xfer_first_out,
    output logic [3:0] xfer_last_out,
    // Flow control
    output logic [31:0] target_out,
    output logic pc_load_out,
    output logic misaligned_exc_out
);

    // ----------------------------------------
    // Latched instruction
    // ----------------------------------------
    logic [15:0] instr_q, instr_d;
    logic [31:0] pc_q, pc_d;
    logic valid_q, valid_d;

    always_comb begin
        instr_d = instr_q;
        pc_d = pc_q;
        valid_d = fetch_valid_in;
        if (fetch_valid_in) begin
            instr_d = fetch_instr_in;
            pc_d = fetch_pc_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            instr_q <= 16'h0000;
            pc_q <= 32'h0000_0000;
            valid_q <= 1'b0;
        end else begin
            instr_q <= instr_d;
            pc_q <= pc_d;
            valid_q <= valid_d;
        end
    end

    // ----------------------------------------
    // Fields
    // ----------------------------------------
    logic [4:0] imm5;
    logic [3:0] nib1;
    rdc_pkg::rdc_op_t op;

    assign imm5 = instr_q[rdc_pkg::IMM_LSB +: rdc_pkg::IMM5_W]; // [RQ14]
    assign nib1 = instr_q[7:4];

    // ----------------------------------------
    // Opcode map
    // ----------------------------------------
    always_comb begin
        op = rdc_pkg::op_illegal; // [RQ23]
        case (instr_q[15:12])
            4'h0: begin
                case (instr_q[11:8])
                    4'h0: begin // [RQ11]
                        case (nib1)
                            4'h0: begin // [RQ10]
                                if (!instr_q[3]) begin
                                    if (instr_q[2:0] != 3'h7) begin
                                        op = rdc_pkg::rdc_op_t'(7'(rdc_pkg::op_debug_halt) + 7'(instr_q[2:0]));
                                    end
                                end else if (instr_q[3:2] == rdc_pkg::TRAP_SEL) begin
                                    op = rdc_pkg::op_trap;
                                end
                            end
                            4'h1: op = rdc_pkg::op_mvc;
                            4'h2: op = rdc_pkg::op_illegal;
                            4'h3: op = rdc_pkg::op_mvcv;
                            default: op = rdc_pkg::rdc_op_t'(7'(rdc_pkg::op_load_quad_regs) + 7'(nib1) - 7'h04);
                        endcase
                    end
                    4'h1: op = rdc_pkg::rdc_op_t'(7'(rdc_pkg::op_xtrb3) + 7'(nib1)); // [RQ11]
                    4'h8, 4'h9: op = rdc_pkg::op_illegal; // [RQ12]
                    4'hA: op = rdc_pkg::op_movf; // [RQ12]
                    4'hB: op = rdc_pkg::op_lsr;
                    4'hC: op = rdc_pkg::op_cmphs;
                    4'hD: op = rdc_pkg::op_cmplt;
                    4'hE: op = rdc_pkg::op_tst;
                    4'hF: op = rdc_pkg::op_cmpne;
                    default: op = rdc_pkg::rdc_op_t'(7'(rdc_pkg::op_movt) + 7'(instr_q[11:8]) - 7'h02);
                endcase
            end
            4'h1: begin
                case (instr_q[11:8])
                    4'h0, 4'h1: op = rdc_pkg::op_control_reg_read; // [RQ13]
                    4'h8, 4'h9: op = rdc_pkg::op_control_reg_write; // [RQ13]
                    4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin // [RQ12]
                        op = rdc_pkg::rdc_op_t'(7'(rdc_pkg::op_mov) + 7'(instr_q[11:8]) - 7'h02);
                    end
                    default: op = rdc_pkg::rdc_op_t'(7'(rdc_pkg::op_asr) + 7'(instr_q[11:8]) - 7'h0A);
                endcase
            end
            4'h2, 4'h3: begin // [RQ14]
                case (instr_q[12:9])
                    4'h0: op = rdc_pkg::op_addi;
                    4'h1: op = rdc_pkg::op_cmplti;
                    4'h2: op = rdc_pkg::op_subi;
                    4'h4: op = rdc_pkg::op_rsubi;
                    4'h5: op = rdc_pkg::op_cmpnei;
                    4'h6: begin // [RQ16]
                        if (imm5 == rdc_pkg::IMM_UDIV) begin
                            op = rdc_pkg::op_unsigned_divide;
                        end else if (imm5 == rdc_pkg::IMM_ZERO || imm5 > rdc_pkg::IMM_BGEN_LOW) begin
                            op = rdc_pkg::op_low_ones_mask_const;
                        end
                    end
                    4'h7: op = rdc_pkg::op_andi;
                    4'h8: op = rdc_pkg::op_bclri;
                    4'h9: begin // [RQ16]
                        if (imm5 == rdc_pkg::IMM_SDIV) begin
                            op = rdc_pkg::op_signed_divide;
                        end else if (imm5 >= rdc_pkg::IMM_BGEN_LOW) begin
                            op = rdc_pkg::op_single_bit_const;
                        end
                    end
                    4'hA: op = rdc_pkg::op_bseti;
                    4'hB: op = rdc_pkg::op_btsti;
                    4'hC: begin // [RQ15]
                        op = (imm5 == rdc_pkg::IMM_ZERO) ? rdc_pkg::op_extended_right_shift
                                                         : rdc_pkg::op_rotate_left_const;
                    end
                    4'hD: op = (imm5 == rdc_pkg::IMM_ZERO) ? rdc_pkg::op_asrc : rdc_pkg::op_asri; // [RQ15]
                    4'hE: begin // [RQ15]
                        op = (imm5 == rdc_pkg::IMM_ZERO) ? rdc_pkg::op_logical_left_shift_carry
                                                         : rdc_pkg::op_lsli;
                    end
                    4'hF: begin // [RQ15]
                        op = (imm5 == rdc_pkg::IMM_ZERO) ? rdc_pkg::op_logical_right_shift_carry
                                                         : rdc_pkg::op_lsri;
                    end
                    default: op = rdc_pkg::op_illegal;
                endcase
            end
            4'h4: begin // [RQ17]
                if (instr_q[9:8] == 2'h0) begin
                    op = rdc_pkg::op_accel_execute;
                end else if (instr_q[9:8] == 2'h1) begin
                    op = instr_q[7] ? rdc_pkg::op_accel_call : rdc_pkg::op_accel_result_fetch;
                end else begin
                    op = rdc_pkg::rdc_op_t'(7'(rdc_pkg::op_accel_mem_load) + 7'({instr_q[8], instr_q[7]}));
                end
            end
            4'h6: if (!instr_q[11]) op = rdc_pkg::op_small_const_load; // [RQ18]
            4'h7: begin // [RQ19]
                if (instr_q[11:8] == rdc_pkg::IND_GOTO_Z) begin
                    op = rdc_pkg::op_indirect_goto;
                end else if (instr_q[11:8] == rdc_pkg::IND_CALL_Z) begin
                    op = rdc_pkg::op_indirect_call;
                end else begin
                    op = rdc_pkg::op_pc_relative_word_load;
                end
            end
            4'hE, 4'hF: begin // [RQ20]
                op = rdc_pkg::rdc_op_t'(7'(rdc_pkg::op_goto_if_set) + 7'(instr_q[12:11]));
            end
            4'h5: op = rdc_pkg::op_illegal;
            default: op = rdc_pkg::rdc_op_t'(7'(rdc_pkg::op_load_word) + 7'(instr_q[15:12]) - 7'h08); // [RQ21]
        endcase
    end

    // ----------------------------------------
    // Address adders
    // ----------------------------------------
    logic [31:0] br_addr, loop_addr, word_addr;

    rdc_pc_adder #(.CLEAR_LOW(1'b0)) u_branch (
        .pc_in(pc_q),
        .offset_in({{20{instr_q[10]}}, instr_q[10:0], 1'b0}), // [RQ7]
        .addr_out(br_addr)
    );

    rdc_pc_adder #(.CLEAR_LOW(1'b0)) u_loop (
        .pc_in(pc_q),
        .offset_in({{27{1'b1}}, instr_q[7:4], 1'b0}), // [RQ9]
        .addr_out(loop_addr)
    );

    rdc_pc_adder #(.CLEAR_LOW(1'b1)) u_word (
        .pc_in(pc_q),
        .offset_in({22'h000000, instr_q[7:0], 2'b00}), // [RQ4] [RQ5]
        .addr_out(word_addr)
    );

    // ----------------------------------------
    // Operands, memory and flow outputs
    // ----------------------------------------
    logic is_ind;

    assign is_ind = valid_q && (op == rdc_pkg::op_indirect_goto || op == rdc_pkg::op_indirect_call);

    always_comb begin
        dec_valid_out = valid_q; // [RQ24]
        dec_op_out = op;
        illegal_out = valid_q && (op == rdc_pkg::op_illegal); // [RQ23]
        rx_sel_out = instr_q[rdc_pkg::RX_LSB +: rdc_pkg::REG_W]; // [RQ11] [RQ8]
        ry_sel_out = instr_q[rdc_pkg::RY_LSB +: rdc_pkg::REG_W]; // [RQ12]
        rz_sel_out = instr_q[rdc_pkg::RZ_LSB +: rdc_pkg::REG_W]; // [RQ21]
        creg_out = imm5; // [RQ13]
        trap_num_out = instr_q[1:0]; // [RQ10]
        accel_unit_out = instr_q[rdc_pkg::UNIT_LSB +: 2]; // [RQ17]
        accel_exec_out = (op == rdc_pkg::op_accel_execute) ? instr_q[7:0] : {4'h0, instr_q[3:0]};
        accel_count_out = instr_q[6:4];
        accel_update_out = instr_q[6];
        imm_out = {27'h0000000, imm5};
        mem_read_out = 1'b0;
        mem_write_out = 1'b0;
        mem_size_out = rdc_pkg::SIZE_WORD;
        mem_addr_out = rx_value_in;
        xfer_first_out = rdc_pkg::QUAD_FIRST;
        xfer_last_out = rdc_pkg::QUAD_LAST;
        target_out = br_addr;
        pc_load_out = 1'b0;
        misaligned_exc_out = 1'b0;
        case (op)
            rdc_pkg::op_addi, rdc_pkg::op_cmplti, rdc_pkg::op_subi: begin
                imm_out = {27'h0000000, imm5} + rdc_pkg::OFFSET_ONE; // [RQ22]
            end
            rdc_pkg::op_low_ones_mask_const: begin
                if (imm5 == rdc_pkg::IMM_ZERO) imm_out = rdc_pkg::MASK_ALL_IMM; // [RQ16]
            end
            rdc_pkg::op_small_const_load: imm_out = {25'h0000000, instr_q[10:4]}; // [RQ18]
            rdc_pkg::op_accel_mem_load, rdc_pkg::op_accel_mem_store,
            rdc_pkg::op_accel_mem_load_half, rdc_pkg::op_accel_mem_store_half: begin
                imm_out = {30'h00000000, instr_q[5:4]}; // [RQ17]
            end
            rdc_pkg::op_load_word, rdc_pkg::op_save_word: begin // [RQ1]
                imm_out = {26'h0000000, instr_q[7:4], 2'b00};
                mem_addr_out = rx_value_in + imm_out;
                mem_read_out = valid_q && !instr_q[12];
                mem_write_out = valid_q && instr_q[12];
            end
            rdc_pkg::op_load_half, rdc_pkg::op_save_half: begin // [RQ1]
                imm_out = {27'h0000000, instr_q[7:4], 1'b0};
                mem_size_out = rdc_pkg::SIZE_HALF;
                mem_addr_out = rx_value_in + imm_out;
                mem_read_out = valid_q && !instr_q[12];
                mem_write_out = valid_q && instr_q[12];
            end
            rdc_pkg::op_load_byte, rdc_pkg::op_save_byte: begin // [RQ1]
                imm_out = {28'h0000000, instr_q[7:4]};
                mem_size_out = rdc_pkg::SIZE_BYTE;
                mem_addr_out = rx_value_in + imm_out;
                mem_read_out = valid_q && !instr_q[12];
                mem_write_out = valid_q && instr_q[12];
            end
            rdc_pkg::op_load_quad_regs, rdc_pkg::op_save_quad_regs: begin // [RQ2]
                mem_read_out = valid_q && (op == rdc_pkg::op_load_quad_regs);
                mem_write_out = valid_q && (op == rdc_pkg::op_save_quad_regs);
            end
            rdc_pkg::op_load_reg_range, rdc_pkg::op_save_reg_range: begin // [RQ3]
                xfer_first_out = instr_q[rdc_pkg::RX_LSB +: rdc_pkg::REG_W];
                xfer_last_out = rdc_pkg::RANGE_LAST;
                mem_addr_out = r0_value_in;
                mem_read_out = valid_q && (op == rdc_pkg::op_load_reg_range);
                mem_write_out = valid_q && (op == rdc_pkg::op_save_reg_range);
            end
            rdc_pkg::op_pc_relative_word_load: begin // [RQ4]
                mem_addr_out = word_addr;
                mem_read_out = valid_q;
            end
            rdc_pkg::op_indirect_goto, rdc_pkg::op_indirect_call: begin // [RQ5]
                mem_addr_out = word_addr;
                mem_read_out = valid_q;
                target_out = ind_word_in;
                pc_load_out = ind_word_valid_in && !ind_word_in[0]; // [RQ6]
                misaligned_exc_out = ind_word_valid_in && ind_word_in[0]; // [RQ6]
            end
            rdc_pkg::op_register_goto, rdc_pkg::op_register_call: target_out = rx_value_in; // [RQ8]
            rdc_pkg::op_loopt: target_out = loop_addr; // [RQ9]
            default: begin
            end
        endcase
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_fetch;
        fetch_valid_in ##1 dec_valid_out;
    endsequence

    a_latch_word: assert property (s_fetch |-> instr_q == $past(fetch_instr_in) && pc_q == $past(fetch_pc_in)) // [RQ24]
        else $error("latched word does not match fetch");
    a_word_addr: assert property (dec_valid_out && instr_q[15:12] == 4'h8 |->
        mem_read_out && mem_addr_out == rx_value_in + {26'h0, instr_q[7:4], 2'b00}) // [RQ1]
        else $error("word load address wrong");
    a_quad_regs: assert property (dec_valid_out && instr_q[15:4] == 12'h004 |->
        xfer_first_out == 4'h4 && xfer_last_out == 4'h7 && mem_addr_out == rx_value_in) // [RQ2]
        else $error("quad transfer fields wrong");
    a_range_regs: assert property (dec_valid_out && instr_q[15:4] == 12'h007 |->
        mem_write_out && xfer_first_out == instr_q[3:0] && xfer_last_out == 4'hF && mem_addr_out == r0_value_in) // [RQ3]
        else $error("range transfer fields wrong");
    a_pcrel_addr: assert property (dec_valid_out && instr_q[15:12] == 4'h7 |->
        mem_addr_out == ((pc_q + 32'h2 + {22'h0, instr_q[7:0], 2'b00}) & 32'hFFFF_FFFC)) // [RQ4] [RQ5]
        else $error("pc relative address wrong");
    a_ind_odd: assert property (is_ind && ind_word_valid_in && ind_word_in[0] |-> misaligned_exc_out && !pc_load_out) // [RQ6]
        else $error("odd indirect target not trapped");
    a_branch_tgt: assert property (dec_valid_out && instr_q[15:13] == 3'h7 |->
        target_out == pc_q + 32'h2 + {{20{instr_q[10]}}, instr_q[10:0], 1'b0}) // [RQ7]
        else $error("branch target wrong");
    a_reg_goto: assert property (dec_valid_out && instr_q[15:5] == 11'h006 |-> target_out == rx_value_in) // [RQ8]
        else $error("register goto target wrong");
    a_loop_tgt: assert property (dec_valid_out && instr_q[15:8] == 8'h04 |->
        target_out == pc_q + 32'h2 - {27'h0, ~instr_q[7:4], 1'b0} - 32'h2) // [RQ9]
        else $error("loop target wrong");
    a_undef_word: assert property (dec_valid_out && (instr_q == 16'h0007 || instr_q[15:9] == 7'h04) |-> illegal_out) // [RQ10] [RQ12] [RQ23]
        else $error("undefined word not flagged");
    a_offset_imm: assert property (dec_valid_out && instr_q[15:11] == 5'h04 && instr_q[10:9] != 2'h3 |->
        imm_out == 32'(instr_q[8:4]) + 32'h1) // [RQ22]
        else $error("offset immediate wrong");

endmodule

/* File: rdc_far_model.sv */
`timescale 1ns/1ps

module rdc_far_model (
    // Decoder requests, and the odd-target select from the test
    input wire logic [3:0] rx_sel_in,
    input wire logic mem_read_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic odd_in,
    // Answers
    output logic [31:0] rx_value_out,
    output logic [31:0] r0_value_out,
    output logic ind_word_valid_out,
    output logic [31:0] ind_word_out
);
    // Register value carries its own number
    assign rx_value_out = {28'hA000000, rx_sel_in};
    assign r0_value_out = 32'h0000_8000;
    // Word answers a read at once; idle bus shows the inverse
    assign ind_word_valid_out = mem_read_in;
    assign ind_word_out = mem_read_in ? {mem_addr_in[31:1], odd_in} : ~mem_addr_in;
endmodule

/* File: risc16_instruction_decoder_tb.sv */
`timescale 1ns/1ps

module risc16_instruction_decoder_tb;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic fv = 1'b0;
    logic [15:0] fw = 16'h0000;
    logic [31:0] fpc = 32'h0000_0000;
    logic odd = 1'b0;
    logic [31:0] rx_v, r0_v, ind_w, imm, addr, tgt;
    logic ind_v, dv, ill, rd, wr, pcl, mis;
    logic [3:0] rz_s, xf, xl;
    logic [1:0] size, trap;
    rdc_pkg::rdc_op_t op;
    int bad_count = 0;
    int total_checks = 0;

    rdc_decoder dut_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .fetch_valid_in(fv),
        .fetch_instr_in(fw), .fetch_pc_in(fpc), .rx_value_in(rx_v), .r0_value_in(r0_v),
        .ind_word_valid_in(ind_v), .ind_word_in(ind_w), .dec_valid_out(dv), .dec_op_out(op),
        .illegal_out(ill), .rx_sel_out(), .ry_sel_out(), .rz_sel_out(rz_s), .creg_out(),
        .imm_out(imm), .trap_num_out(trap), .accel_unit_out(), .accel_exec_out(), .accel_count_out(),
        .accel_update_out(), .mem_read_out(rd), .mem_write_out(wr), .mem_size_out(size),
        .mem_addr_out(addr), .xfer_first_out(xf), .xfer_last_out(xl), .target_out(tgt),
        .pc_load_out(pcl), .misaligned_exc_out(mis));
    rdc_far_model far_u (.rx_sel_in(dut_u.rx_sel_out), .mem_read_in(rd), .mem_addr_in(addr),
        .odd_in(odd), .rx_value_out(rx_v), .r0_value_out(r0_v), .ind_word_valid_out(ind_v),
        .ind_word_out(ind_w));

    initial begin
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    task automatic chk_v(input logic [79:0] got, input logic [79:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_op(input rdc_pkg::rdc_op_t got, input rdc_pkg::rdc_op_t exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t op %s expected %s", $time, got.name(), exp.name());
        end
    endtask

    task automatic issue(input logic [15:0] w, input logic [31:0] pc);
        @(posedge core_clk_in);
        #1 fv = 1'b1;
        fw = w;
        fpc = pc;
        @(posedge core_clk_in);
        #1 fv = 1'b0;
        chk_v(dv, 1'b1);
    endtask

    task automatic t_mem();
        issue(16'h8123, 32'h0);
        chk_op(op, rdc_pkg::op_load_word);
        chk_v(addr, 32'hA000_000B);
        chk_v({rz_s, size, rd}, {4'h1, rdc_pkg::SIZE_WORD, 1'b1});
        issue(16'hD123, 32'h0);
        chk_v({addr, wr, size}, {32'hA000_0007, 1'b1, rdc_pkg::SIZE_HALF});
        issue(16'hA123, 32'h0);
        chk_v(addr, 32'hA000_0005);
        issue(16'h0045, 32'h0);
        chk_v({addr, xf, xl}, {32'hA000_0005, 8'h47});
        issue(16'h0079, 32'h0);
        chk_op(op, rdc_pkg::op_save_reg_range);
        chk_v({addr, xf, xl}, {32'h0000_8000, 8'h9F});
        $display("test mem done");
    endtask

    task automatic t_flow();
        issue(16'hF7FF, 32'h100);
        chk_v(tgt, 32'h100);
        issue(16'hFC00, 32'h1000);
        chk_op(op, rdc_pkg::op_relative_call);
        chk_v(tgt, 32'h802);
        issue(16'h00C6, 32'h0);
        chk_v(tgt, 32'hA000_0006);
        issue(16'h0403, 32'h200);
        chk_v(tgt, 32'h1E2);
        issue(16'h7005, 32'h100);
        chk_v({addr, tgt, pcl, mis}, {32'h114, 32'h114, 2'b10});
        odd = 1'b1;
        issue(16'h7F05, 32'h100);
        chk_op(op, rdc_pkg::op_indirect_call);
        chk_v({pcl, mis}, 2'b01);
        odd = 1'b0;
        issue(16'h7305, 32'h104);
        chk_v({addr, rz_s, rd}, {32'h118, 4'h3, 1'b1});
        $display("test flow done");
    endtask

    task automatic t_codes();
        for (int i = 0; i < 7; i++) begin
            issue(16'(i), 32'h0);
            chk_op(op, rdc_pkg::rdc_op_t'(i + 1));
        end
        issue(16'h0007, 32'h0);
        chk_v(ill, 1'b1);
        issue(16'h0912, 32'h0);
        chk_v({ill, rd, wr}, 3'b100);
        issue(16'h000A, 32'h0);
        chk_v({ill, trap}, 3'b010);
        issue(16'h3800, 32'h0);
        chk_op(op, rdc_pkg::op_extended_right_shift);
        issue(16'h2000, 32'h0);
        chk_v(imm, 32'h1);
        issue(16'h2C03, 32'h0);
        chk_v(imm, 32'h20);
        issue(16'h2C13, 32'h0);
        chk_op(op, rdc_pkg::op_unsigned_divide);
        issue(16'h67F2, 32'h0);
        chk_op(op, rdc_pkg::op_small_const_load);
        chk_v(imm, 32'h7F);
        issue(16'h3210, 32'h0);
        chk_op(op, rdc_pkg::op_signed_divide);
        issue(16'h4C85, 32'h0);
        chk_op(op, rdc_pkg::op_accel_execute);
        $display("test codes done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge core_clk_in);
        #1 sys_rst_in = 1'b0;
        chk_v({dv, rd, wr, pcl, mis, ill}, 6'h00);
        t_mem();
        t_flow();
        t_codes();
        stop_test();
    end
endmodule
